// ===== bldc_consts.vh
// constants and timing counts for the brushless commutation and chop control block
// Summary of operation
// - each new latched rotor position emits one fixed-width speed pulse, nominally 113 us.
// - position latches stay frozen while the speed pulse is high.
// - chop select low gives half control: only low-side switches chop.
// - chop select high gives full control: all six switches chop.
// - during braking the chop select input has no effect.
// - PWM comparator assertion clears the PWM latch, chopping the rest of the cycle.
// - peak-current indication also ends conduction for the current cycle.
// - overcurrent starts soft-start and disables all phases while it persists.
// - oscillator, speed pulse, direction and phases stay inactive until the 5 V reference is in regulation.
// - a free-running 14.8 kHz oscillator sets the chopping period, under 20 kHz.
// - braking turns off all high-side drivers and turns on all low-side drivers.
// - coast input forces all three phases high-impedance regardless of other inputs.
// - direction passes a latch and two oscillator-clocked stages; mismatch forces Hi-Z.
// - soft-start latch sets on undervoltage or overcurrent, clears below threshold, fault-free.
`ifndef BLDC_CONSTS_VH
`define BLDC_CONSTS_VH

`define SYS_CLK_PERIOD_NS 25
`define PWM_FREQ_HZ 14800
`define PWM_FREQ_MAX_HZ 20000
`define PWM_PERIOD_CYC (1000000000 / (`PWM_FREQ_HZ * `SYS_CLK_PERIOD_NS))
`define PWM_CNT_W 12
`define TACH_ON_NS 113000
`define TACH_ON_CYC ((`TACH_ON_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define TACH_CNT_W 13

// bit positions of the synchronised pin vector
`define IN_POS_A 0
`define IN_POS_B 1
`define IN_POS_C 2
`define IN_DIR 3
`define IN_CHOP_SEL 4
`define IN_BRAKE 5
`define IN_COAST 6
`define IN_PWM_CMP 7
`define IN_PEAK 8
`define IN_OVER_CUR 9
`define IN_UNDER_VOLT 10
`define IN_REF_OK 11
`define IN_SS_LOW 12
`define IN_SPEED_HI 13
`define IN_COUNT 14

`endif

// ===== bldc_dir_filter.v
// direction latch, two-stage shift register and mismatch inhibit
`default_nettype none
module bldc_dir_filter (
  input wire clk,
  input wire rst,
  input wire enable,
  input wire osc_tick,
  input wire dir_in,
  input wire latch_hold,
  output wire dir_out,
  output wire mismatch
);
  reg latch_q;
  reg stage1_q;
  reg stage2_q;

  // latch is transparent while the motor is slow; stages advance on oscillator ticks
  always @(posedge clk) begin
    if (rst || !enable) begin
      latch_q <= 1'b0;
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end else begin
      if (!latch_hold) begin
        latch_q <= dir_in;
      end
      if (osc_tick) begin
        stage1_q <= latch_q;
        stage2_q <= stage1_q;
      end
    end
  end

  // a stage disagreement gives one to two oscillator cycles of dead time; with the latch held, an input disagreement lasts until it opens
  assign mismatch = (dir_in != latch_q) | (latch_q != stage1_q) | (stage1_q != stage2_q);
  assign dir_out = stage2_q;
endmodule
`default_nettype wire

// ===== bldc_commutation_chop_control.v
// three-phase brushless commutation, chop gating, speed pulse and fault control
`include "bldc_consts.vh"
`default_nettype none
module bldc_commutation_chop_control #(
  parameter integer TACH_CYC = `TACH_ON_CYC
) (
  input wire SYS_CLK,
  input wire RST,
  input wire ROTOR_POS_A,
  input wire ROTOR_POS_B,
  input wire ROTOR_POS_C,
  input wire DIR_REQ,
  input wire CHOP_SCOPE_SEL,
  input wire BRAKE_REQ,
  input wire COAST_REQ,
  input wire PWM_CMP,
  input wire PEAK_CUR,
  input wire OVER_CUR,
  input wire UNDER_VOLT,
  input wire REF_OK,
  input wire SS_BELOW_THR,
  input wire SPEED_ABOVE_THR,
  output reg TACH_OUT,
  output reg PHASE_A_HI_EN,
  output reg PHASE_A_LO_EN,
  output reg PHASE_B_HI_EN,
  output reg PHASE_B_LO_EN,
  output reg PHASE_C_HI_EN,
  output reg PHASE_C_LO_EN,
  output reg SOFTSTART_CLAMP,
  output reg FULL_MODE
);
  // terminal counts worked out at full width, then cut to the counter width on purpose
  localparam [31:0] PWM_LAST_W = `PWM_PERIOD_CYC - 1;
  localparam [31:0] TACH_LAST_W = TACH_CYC - 1;
  localparam [`PWM_CNT_W-1:0] PWM_LAST = PWM_LAST_W[`PWM_CNT_W-1:0];
  localparam [`TACH_CNT_W-1:0] TACH_LAST = TACH_LAST_W[`TACH_CNT_W-1:0];

  // decode position and direction into {a_src,a_snk,b_src,b_snk,c_src,c_snk}
  function [5:0] phase_decode;
    input dir;
    input [2:0] pos;
    reg [5:0] fwd;
    begin
      fwd = 6'h00;
      case (pos)
        3'h1: fwd = 6'h06; // b sink, c source
        3'h3: fwd = 6'h12; // a sink, c source
        3'h2: fwd = 6'h18; // a sink, b source
        3'h6: fwd = 6'h09; // b source, c sink
        3'h4: fwd = 6'h21; // a source, c sink
        3'h5: fwd = 6'h24; // a source, b sink
        default: fwd = 6'h00; // illegal 000 and 111 leave every phase open
      endcase
      // reverse direction swaps source and sink on every phase
      if (dir) begin
        phase_decode = fwd;
      end else begin
        phase_decode = {fwd[4], fwd[5], fwd[2], fwd[3], fwd[0], fwd[1]};
      end
    end
  endfunction

  wire [`IN_COUNT-1:0] raw_in;
  wire [`IN_COUNT-1:0] pin;

  assign raw_in = {SPEED_ABOVE_THR, SS_BELOW_THR, REF_OK, UNDER_VOLT, OVER_CUR, PEAK_CUR,
                   PWM_CMP, COAST_REQ, BRAKE_REQ, CHOP_SCOPE_SEL, DIR_REQ,
                   ROTOR_POS_C, ROTOR_POS_B, ROTOR_POS_A};

  // three sync flops and a filter flop per pin; the filtered value moves only when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `IN_COUNT; gi = gi + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg filt_q;
      always @(posedge SYS_CLK) begin
        if (RST) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          filt_q <= 1'b0;
        end else begin
          s1_q <= raw_in[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            filt_q <= s3_q;
          end
        end
      end
      assign pin[gi] = filt_q;
    end
  endgenerate

  wire ref_ok = pin[`IN_REF_OK];
  wire over_cur = pin[`IN_OVER_CUR];
  wire under_volt = pin[`IN_UNDER_VOLT];
  wire braking = pin[`IN_BRAKE];
  wire coast = pin[`IN_COAST];
  wire [2:0] pos_now = {pin[`IN_POS_A], pin[`IN_POS_B], pin[`IN_POS_C]};

  reg [`PWM_CNT_W-1:0] osc_cnt_q;
  reg osc_tick_q;

  // free-running chop oscillator; held idle until the reference is good
  always @(posedge SYS_CLK) begin
    if (RST || !ref_ok) begin
      osc_cnt_q <= {`PWM_CNT_W{1'b0}};
      osc_tick_q <= 1'b0;
    end else if (osc_cnt_q == PWM_LAST) begin
      osc_cnt_q <= {`PWM_CNT_W{1'b0}};
      osc_tick_q <= 1'b1;
    end else begin
      osc_cnt_q <= osc_cnt_q + 1'b1;
      osc_tick_q <= 1'b0;
    end
  end

  reg pwm_on_q;

  // pwm latch sets at each cycle start; either comparator clears it until the next start.
  // a comparator still asserted at the cycle start wins, so no conduction sliver leaks out
  always @(posedge SYS_CLK) begin
    if (RST || !ref_ok) begin
      pwm_on_q <= 1'b0;
    end else if (pin[`IN_PWM_CMP]) begin
      pwm_on_q <= 1'b0;
    end else if (pin[`IN_PEAK]) begin
      pwm_on_q <= 1'b0;
    end else if (osc_tick_q) begin
      pwm_on_q <= 1'b1;
    end
  end

  reg [2:0] pos_q;
  reg [`TACH_CNT_W-1:0] tach_cnt_q;

  // position latch and speed pulse; latches freeze for the whole pulse to reject chop noise
  always @(posedge SYS_CLK) begin
    if (RST || !ref_ok) begin
      pos_q <= 3'h0;
      tach_cnt_q <= {`TACH_CNT_W{1'b0}};
      TACH_OUT <= 1'b0;
    end else if (TACH_OUT) begin
      // a change during the pulse is caught once it ends, if still present
      if (tach_cnt_q == TACH_LAST) begin
        TACH_OUT <= 1'b0;
        tach_cnt_q <= {`TACH_CNT_W{1'b0}};
      end else begin
        tach_cnt_q <= tach_cnt_q + 1'b1;
      end
    end else if (pos_now != pos_q) begin
      pos_q <= pos_now;
      TACH_OUT <= 1'b1;
      tach_cnt_q <= {`TACH_CNT_W{1'b0}};
    end
  end

  // soft-start latch; fault sets it and the set dominates the clear
  always @(posedge SYS_CLK) begin
    if (RST) begin
      SOFTSTART_CLAMP <= 1'b1;
    end else if (under_volt || over_cur) begin
      SOFTSTART_CLAMP <= 1'b1;
    end else if (pin[`IN_SS_LOW]) begin
      SOFTSTART_CLAMP <= 1'b0;
    end
  end

  // chop scope is sampled only outside braking
  always @(posedge SYS_CLK) begin
    if (RST) begin
      FULL_MODE <= 1'b0;
    end else if (!braking) begin
      FULL_MODE <= pin[`IN_CHOP_SEL];
    end
  end

  wire dir_eff;
  wire dir_mismatch;

  bldc_dir_filter u_dir (
    .clk(SYS_CLK),
    .rst(RST),
    .enable(ref_ok),
    .osc_tick(osc_tick_q),
    .dir_in(pin[`IN_DIR]),
    .latch_hold(pin[`IN_SPEED_HI]),
    .dir_out(dir_eff),
    .mismatch(dir_mismatch)
  );

  reg [5:0] drive;
  reg [2:0] hi_d;
  reg [2:0] lo_d;

  // output gating in priority order: disable, coast, overcurrent, direction mismatch, brake, chop, then commutation
  always @* begin
    drive = phase_decode(dir_eff, pos_q);
    hi_d = {drive[5], drive[3], drive[1]};
    lo_d = {drive[4], drive[2], drive[0]};
    if (!ref_ok) begin
      hi_d = 3'h0;
      lo_d = 3'h0;
    end else if (coast) begin
      hi_d = 3'h0;
      lo_d = 3'h0;
    end else if (over_cur) begin
      hi_d = 3'h0;
      lo_d = 3'h0;
    end else if (dir_mismatch) begin
      hi_d = 3'h0;
      lo_d = 3'h0;
    end else if (braking) begin
      hi_d = 3'h0;
      lo_d = 3'h7;
    end else if (!pwm_on_q) begin
      lo_d = 3'h0;
      if (FULL_MODE) begin
        hi_d = 3'h0;
      end
    end
  end

  // registered switch enables; both off means the phase floats
  always @(posedge SYS_CLK) begin
    if (RST) begin
      PHASE_A_HI_EN <= 1'b0;
      PHASE_B_HI_EN <= 1'b0;
      PHASE_C_HI_EN <= 1'b0;
      PHASE_A_LO_EN <= 1'b0;
      PHASE_B_LO_EN <= 1'b0;
      PHASE_C_LO_EN <= 1'b0;
    end else begin
      PHASE_A_HI_EN <= hi_d[2];
      PHASE_B_HI_EN <= hi_d[1];
      PHASE_C_HI_EN <= hi_d[0];
      PHASE_A_LO_EN <= lo_d[2];
      PHASE_B_LO_EN <= lo_d[1];
      PHASE_C_LO_EN <= lo_d[0];
    end
  end
endmodule
`default_nettype wire

// ===== bldc_cc_assertions.sv
// bound port checks for the commutation and chop control block
`default_nettype none
module bldc_cc_assertions #(
  parameter integer TACH_CYC = 8
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic REF_OK,
  input wire logic COAST_REQ,
  input wire logic OVER_CUR,
  input wire logic BRAKE_REQ,
  input wire logic PWM_CMP,
  input wire logic PEAK_CUR,
  input wire logic CHOP_SCOPE_SEL,
  input wire logic TACH_OUT,
  input wire logic FULL_MODE,
  input wire logic SOFTSTART_CLAMP,
  input wire logic PHASE_A_HI_EN,
  input wire logic PHASE_B_HI_EN,
  input wire logic PHASE_C_HI_EN,
  input wire logic PHASE_A_LO_EN,
  input wire logic PHASE_B_LO_EN,
  input wire logic PHASE_C_LO_EN
);
  timeunit 1ns;
  timeprecision 1ps;
  wire hi = PHASE_A_HI_EN | PHASE_B_HI_EN | PHASE_C_HI_EN;
  wire lo = PHASE_A_LO_EN | PHASE_B_LO_EN | PHASE_C_LO_EN;
  logic [13:0] tcnt_q;
  // inputs cross a sync and agree filter, so eight held cycles cover its latency
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  // counts the high cycles of the speed pulse
  always @(posedge SYS_CLK) tcnt_q <= (RST || !TACH_OUT) ? 14'h0000 : tcnt_q + 14'h0001;
  sequence s_clr;
    ((PWM_CMP || PEAK_CUR) && !BRAKE_REQ)[*8];
  endsequence
  a_tach_width: assert property ($fell(TACH_OUT) |-> tcnt_q == 14'(TACH_CYC))
    else $error("speed pulse width wrong");
  a_tach_max: assert property (tcnt_q <= 14'(TACH_CYC))
    else $error("speed pulse too long");
  a_coast_off: assert property (COAST_REQ[*8] |-> !hi && !lo)
    else $error("phase on during coast");
  a_oc_off: assert property (OVER_CUR[*8] |-> !hi && !lo && SOFTSTART_CLAMP)
    else $error("phase on or clamp off during overcurrent");
  a_ref_off: assert property (!REF_OK[*8] |-> !hi && !lo && !TACH_OUT)
    else $error("activity before reference ok");
  a_brake_hi: assert property (BRAKE_REQ[*8] |-> !hi)
    else $error("high side on during brake");
  a_brake_mode: assert property (BRAKE_REQ[*8] ##1 BRAKE_REQ |-> $stable(FULL_MODE))
    else $error("mode moved during brake");
  a_mode_follow: assert property (($stable(CHOP_SCOPE_SEL) && !BRAKE_REQ)[*8]
    |-> FULL_MODE == CHOP_SCOPE_SEL) else $error("mode does not follow select");
  a_half_chop: assert property (s_clr |-> !lo)
    else $error("low side on while latch cleared");
  a_full_chop: assert property (s_clr ##0 FULL_MODE |-> !hi)
    else $error("high side on in full mode chop");
  a_no_shoot: assert property (!(PHASE_A_HI_EN && PHASE_A_LO_EN)
    && !(PHASE_B_HI_EN && PHASE_B_LO_EN) && !(PHASE_C_HI_EN && PHASE_C_LO_EN))
    else $error("both switches of a phase on");
endmodule
bind bldc_commutation_chop_control bldc_cc_assertions #(
  .TACH_CYC(TACH_CYC)
) chk (
  .SYS_CLK(SYS_CLK),
  .RST(RST),
  .REF_OK(REF_OK),
  .COAST_REQ(COAST_REQ),
  .OVER_CUR(OVER_CUR),
  .BRAKE_REQ(BRAKE_REQ),
  .PWM_CMP(PWM_CMP),
  .PEAK_CUR(PEAK_CUR),
  .CHOP_SCOPE_SEL(CHOP_SCOPE_SEL),
  .TACH_OUT(TACH_OUT),
  .FULL_MODE(FULL_MODE),
  .SOFTSTART_CLAMP(SOFTSTART_CLAMP),
  .PHASE_A_HI_EN(PHASE_A_HI_EN),
  .PHASE_B_HI_EN(PHASE_B_HI_EN),
  .PHASE_C_HI_EN(PHASE_C_HI_EN),
  .PHASE_A_LO_EN(PHASE_A_LO_EN),
  .PHASE_B_LO_EN(PHASE_B_LO_EN),
  .PHASE_C_LO_EN(PHASE_C_LO_EN)
);
`default_nettype wire

// ===== bldc_hall_model.sv
// rotor position sensor model stepping the grey-coded sensor sequence
`default_nettype none
module bldc_hall_model (
  input wire logic clk,
  input wire logic step,
  output logic [2:0] pos
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] idx_q = 3'h0;
  // one sensor edge per step, so the code never jumps two bits at once
  always @(posedge clk) begin
    if (step) idx_q <= (idx_q == 3'h5) ? 3'h0 : idx_q + 3'h1;
  end
  // sensor levels for each rotor sector
  always_comb begin
    case (idx_q)
      3'h0: pos = 3'h5;
      3'h1: pos = 3'h4;
      3'h2: pos = 3'h6;
      3'h3: pos = 3'h2;
      3'h4: pos = 3'h3;
      default: pos = 3'h1;
    endcase
  end
endmodule
`default_nettype wire

// ===== bldc_commutation_chop_control_test.sv
// self-checking bench for the commutation and chop control block
`default_nettype none
module bldc_commutation_chop_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 1'b0, RST = 1'b1, DIR_REQ = 1'b0, CHOP_SCOPE_SEL = 1'b0, BRAKE_REQ = 1'b0;
  logic COAST_REQ = 1'b0, PWM_CMP = 1'b0, PEAK_CUR = 1'b0, OVER_CUR = 1'b0, UNDER_VOLT = 1'b0;
  logic REF_OK = 1'b0, SS_BELOW_THR = 1'b0, SPEED_ABOVE_THR = 1'b0, step = 1'b0;
  wire TACH_OUT, PHASE_A_HI_EN, PHASE_A_LO_EN, PHASE_B_HI_EN, PHASE_B_LO_EN;
  wire PHASE_C_HI_EN, PHASE_C_LO_EN, SOFTSTART_CLAMP, FULL_MODE;
  wire [2:0] pos;
  wire [8:0] st = {TACH_OUT, SOFTSTART_CLAMP, FULL_MODE, PHASE_A_HI_EN, PHASE_A_LO_EN,
    PHASE_B_HI_EN, PHASE_B_LO_EN, PHASE_C_HI_EN, PHASE_C_LO_EN};
  // expected switch pattern per sector with direction low
  logic [5:0] tbl [6] = '{6'h18, 6'h12, 6'h06, 6'h24, 6'h21, 6'h09};
  int k = 0, n_fail = 0, checked = 0;
  always #12.5 SYS_CLK = ~SYS_CLK;
  bldc_hall_model hall (.clk(SYS_CLK), .step(step), .pos(pos));
  bldc_commutation_chop_control #(.TACH_CYC(8)) uut (
    .SYS_CLK(SYS_CLK),
    .RST(RST),
    .ROTOR_POS_A(pos[2]),
    .ROTOR_POS_B(pos[1]),
    .ROTOR_POS_C(pos[0]),
    .DIR_REQ(DIR_REQ),
    .CHOP_SCOPE_SEL(CHOP_SCOPE_SEL),
    .BRAKE_REQ(BRAKE_REQ),
    .COAST_REQ(COAST_REQ),
    .PWM_CMP(PWM_CMP),
    .PEAK_CUR(PEAK_CUR),
    .OVER_CUR(OVER_CUR),
    .UNDER_VOLT(UNDER_VOLT),
    .REF_OK(REF_OK),
    .SS_BELOW_THR(SS_BELOW_THR),
    .SPEED_ABOVE_THR(SPEED_ABOVE_THR),
    .TACH_OUT(TACH_OUT),
    .PHASE_A_HI_EN(PHASE_A_HI_EN),
    .PHASE_A_LO_EN(PHASE_A_LO_EN),
    .PHASE_B_HI_EN(PHASE_B_HI_EN),
    .PHASE_B_LO_EN(PHASE_B_LO_EN),
    .PHASE_C_HI_EN(PHASE_C_HI_EN),
    .PHASE_C_LO_EN(PHASE_C_LO_EN),
    .SOFTSTART_CLAMP(SOFTSTART_CLAMP),
    .FULL_MODE(FULL_MODE)
  );
  function automatic logic [5:0] sw(input logic [5:0] e);
    return {e[4], e[5], e[2], e[3], e[0], e[1]};
  endfunction
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge SYS_CLK);
  endtask
  task automatic go;
    step = 1'b1;
    tick(1);
    step = 1'b0;
    k = (k + 1) % 6;
  endtask
  // bounded wait for the speed pulse
  task automatic wait_tach;
    int i;
    i = 0;
    while (TACH_OUT !== 1'b1 && i < 40) begin
      tick(1);
      i++;
    end
    chk({st[8], 8'h00}, 9'h100);
  endtask
  task automatic test_done;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_start;
    chk(st, 9'h080);
    go();
    tick(12);
    chk(st, 9'h080);
    REF_OK = 1'b1;
    SS_BELOW_THR = 1'b1;
    tick(3000);
    chk(st, {3'h0, tbl[k]});
    $display("start done");
  endtask
  task automatic t_decode;
    repeat (6) begin
      go();
      wait_tach();
      tick(12);
      chk(st, {3'h0, tbl[k]});
    end
    $display("decode done");
  endtask
  // second sensor edge lands inside the pulse and must wait for it
  task automatic t_freeze;
    go();
    wait_tach();
    go();
    tick(5);
    chk(st, {3'h4, tbl[(k + 5) % 6]});
    tick(5);
    wait_tach();
    tick(12);
    chk(st, {3'h0, tbl[k]});
    $display("freeze done");
  endtask
  task automatic t_dir;
    DIR_REQ = 1'b1;
    tick(10);
    chk(st, 9'h000);
    tick(6000);
    chk(st, {3'h0, sw(tbl[k])});
    SPEED_ABOVE_THR = 1'b1;
    DIR_REQ = 1'b0;
    tick(10);
    chk(st, 9'h000);
    SPEED_ABOVE_THR = 1'b0;
    tick(6000);
    chk(st, {3'h0, tbl[k]});
    $display("direction done");
  endtask
  task automatic t_faults;
    COAST_REQ = 1'b1;
    tick(10);
    chk(st, 9'h000);
    COAST_REQ = 1'b0;
    OVER_CUR = 1'b1;
    tick(10);
    chk(st, 9'h080);
    OVER_CUR = 1'b0;
    UNDER_VOLT = 1'b1;
    tick(10);
    chk(st, {3'h2, tbl[k]});
    UNDER_VOLT = 1'b0;
    SS_BELOW_THR = 1'b0;
    tick(10);
    chk(st, {3'h2, tbl[k]});
    SS_BELOW_THR = 1'b1;
    tick(10);
    chk(st, {3'h0, tbl[k]});
    BRAKE_REQ = 1'b1;
    tick(10);
    chk(st, 9'h015);
    CHOP_SCOPE_SEL = 1'b1;
    tick(10);
    chk(st, 9'h015);
    BRAKE_REQ = 1'b0;
    tick(10);
    chk(st, {3'h1, tbl[k]});
    $display("faults done");
  endtask
  task automatic t_chop;
    PWM_CMP = 1'b1;
    tick(10);
    chk(st, 9'h040);
    PWM_CMP = 1'b0;
    CHOP_SCOPE_SEL = 1'b0;
    tick(10);
    chk(st, {3'h0, tbl[k] & 6'h2a});
    tick(2800);
    chk(st, {3'h0, tbl[k]});
    PEAK_CUR = 1'b1;
    tick(10);
    chk(st, {3'h0, tbl[k] & 6'h2a});
    PEAK_CUR = 1'b0;
    $display("chop done");
  endtask
  initial begin
    tick(2);
    RST = 1'b0;
    t_start();
    t_decode();
    t_freeze();
    t_dir();
    t_faults();
    t_chop();
    test_done();
  end
  // the tests need about half a millisecond; a hang ends the run as a failure
  initial begin
    #1ms;
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
